// file: shared/bps_consts.vh
// Purpose: constants for the primary status, class code and cache line registers
// Assumes: dword addresses on the configuration port, active-low byte enables
// Notes:   definitions only
`ifndef BPS_CONSTS_VH
`define BPS_CONSTS_VH

`define BPS_ADDR_STATUS      8'h04
`define BPS_ADDR_CLASS       8'h08
`define BPS_ADDR_CACHE       8'h0C

`define BPS_BIT_CAP_LIST     4
`define BPS_BIT_SPEED        5
`define BPS_BIT_FAST_B2B     7
`define BPS_BIT_DATA_PAR     8
`define BPS_SEL_LO           9
`define BPS_SEL_HI           10
`define BPS_BIT_SIG_TABORT   11
`define BPS_BIT_RCV_TABORT   12
`define BPS_BIT_RCV_MABORT   13
`define BPS_BIT_SIG_SERR     14
`define BPS_BIT_DET_PAR      15

`define BPS_SEL_SPEED_MEDIUM 2'h1
`define BPS_REV_CODE         8'h5A
`define BPS_PROG_IF          8'h00
`define BPS_SUBCLASS         8'h04
`define BPS_BASE_CLASS       8'h06
`define BPS_CACHE_RESET      8'h00
`define BPS_LINE_DEFAULT     8'h10
`define BPS_FLAGS_RESET      5'h00
`define BPS_PERR_RESP_BIT    6
`define BPS_HW_LSB           16

`endif

// file: design/bps_line_size.v
// Purpose: effective cache line length from the programmed byte
// Assumes: input comes from a register on the same clock
// Notes:   registered output
`timescale 1ns/1ps
`include "bps_consts.vh"
module bps_line_size (
	input  wire       clk,
	input  wire       nrst,
	input  wire [7:0] cache_line_size,
	output reg  [7:0] line_dwords
);
	wire power_of_two;
	wire too_big;

	assign power_of_two = (cache_line_size != 8'h00) &&
		((cache_line_size & (cache_line_size - 8'h01)) == 8'h00);
	assign too_big = cache_line_size > `BPS_LINE_DEFAULT;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_dwords <= `BPS_LINE_DEFAULT;
		end else if (power_of_two && !too_big) begin
			line_dwords <= cache_line_size;
		end else begin
			line_dwords <= `BPS_LINE_DEFAULT;
		end
	end
endmodule // bps_line_size

// file: design/bps_regs.v
// Purpose: primary status halfword, class code dword and cache line size byte
// Assumes: one configuration access per cycle on cfg_rd or cfg_wr, same clock
// Notes:   event inputs are one-cycle pulses from primary master and target logic
//
// Overview of operation
// - status bits 19:16 and 22 read zero
// - bit 20 always one, capability list present
// - bit 21 mirrors the speed strap pin
// - bit 23 reads one, read-only
// - bit 24 set: mastering, parity error, response enabled
// - bits 26:25 read constant 01b
// - bit 27 set on signalled target abort
// - bit 28 set on received target abort
// - bit 29 set on received master abort
// - bit 30 set when system error driven
// - bit 31 set on detected data or address parity error
// - status at dword 0x04, upper byte lanes
// - programming interface byte reads zero
// - subclass byte reads 0x04
// - base class byte reads 0x06
// - revision byte returns fixed code
// - cache line size read/write, reset zero
// - bad line size behaves as sixteen
// - command bit 6 gates data parity flag
`timescale 1ns/1ps
`include "bps_consts.vh"
module bps_regs (
	input  wire        clk,
	input  wire        nrst,
	input  wire        cfg_rd,
	input  wire        cfg_wr,
	input  wire [7:0]  cfg_addr,
	input  wire [3:0]  primary_byte_enables_n,
	input  wire [31:0] cfg_wdata,
	output reg  [31:0] cfg_rdata,
	output reg         cfg_ack,
	input  wire        parity_resp_en,
	input  wire        speed_strap_pin,
	input  wire        primary_parity_error_pin_n,
	input  wire        master_active,
	input  wire        parity_err_det,
	input  wire        addr_parity_err,
	input  wire        tgt_abort_signalled,
	input  wire        tgt_abort_received,
	input  wire        mst_abort_received,
	input  wire        system_error_driven,
	output reg  [7:0]  cache_line_size,
	output wire [7:0]  line_dwords
);
	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	reg  [1:0] strap_sync;
	reg  [1:0] perr_sync;
	reg        speed_ok;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_sync <= 2'h0;
			perr_sync  <= 2'h3;
			speed_ok   <= 1'b0;
		end else begin
			strap_sync <= {strap_sync[0], speed_strap_pin};
			perr_sync  <= {perr_sync[0], primary_parity_error_pin_n};
			speed_ok   <= strap_sync[1];
		end
	end

	// -----------------------------------------------------------------
	// sticky error flags
	// -----------------------------------------------------------------
	reg        data_par;
	reg        sig_tabort;
	reg        rcv_tabort;
	reg        rcv_mabort;
	reg        sig_serr;
	reg        det_par;
	wire       wr_status;
	wire       wr_hi;
	wire       perr_seen;

	assign wr_status = cfg_wr && (cfg_addr == `BPS_ADDR_STATUS);
	// all clearable flags, bit 24 too, sit in the top byte lane
	assign wr_hi     = wr_status && !primary_byte_enables_n[3];
	assign perr_seen = !perr_sync[1] || parity_err_det;

	// set wins over a same-cycle clear; zero writes leave flags alone
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_par   <= 1'b0;
			sig_tabort <= 1'b0;
			rcv_tabort <= 1'b0;
			rcv_mabort <= 1'b0;
			sig_serr   <= 1'b0;
			det_par    <= 1'b0;
		end else begin
			if (master_active && perr_seen && parity_resp_en) begin
				data_par <= 1'b1;
			end else if (wr_hi && cfg_wdata[`BPS_HW_LSB + `BPS_BIT_DATA_PAR]) begin
				data_par <= 1'b0;
			end
			if (tgt_abort_signalled) begin
				sig_tabort <= 1'b1;
			end else if (wr_hi && cfg_wdata[`BPS_HW_LSB + `BPS_BIT_SIG_TABORT]) begin
				sig_tabort <= 1'b0;
			end
			if (tgt_abort_received) begin
				rcv_tabort <= 1'b1;
			end else if (wr_hi && cfg_wdata[`BPS_HW_LSB + `BPS_BIT_RCV_TABORT]) begin
				rcv_tabort <= 1'b0;
			end
			if (mst_abort_received) begin
				rcv_mabort <= 1'b1;
			end else if (wr_hi && cfg_wdata[`BPS_HW_LSB + `BPS_BIT_RCV_MABORT]) begin
				rcv_mabort <= 1'b0;
			end
			if (system_error_driven) begin
				sig_serr <= 1'b1;
			end else if (wr_hi && cfg_wdata[`BPS_HW_LSB + `BPS_BIT_SIG_SERR]) begin
				sig_serr <= 1'b0;
			end
			if (parity_err_det || addr_parity_err) begin
				det_par <= 1'b1;
			end else if (wr_hi && cfg_wdata[`BPS_HW_LSB + `BPS_BIT_DET_PAR]) begin
				det_par <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// cache line size
	// -----------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cache_line_size <= `BPS_CACHE_RESET;
		end else if (cfg_wr && (cfg_addr == `BPS_ADDR_CACHE) &&
			!primary_byte_enables_n[0]) begin
			cache_line_size <= cfg_wdata[7:0];
		end
	end

	bps_line_size u_line (
		.clk             (clk),
		.nrst            (nrst),
		.cache_line_size (cache_line_size),
		.line_dwords     (line_dwords)
	);

	// -----------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------
	reg  [15:0] status_hw;
	reg  [31:0] next_rdata;

	always @* begin
		status_hw = 16'h0000;
		status_hw[`BPS_BIT_CAP_LIST]   = 1'b1;
		status_hw[`BPS_BIT_SPEED]      = speed_ok;
		status_hw[`BPS_BIT_FAST_B2B]   = 1'b1;
		status_hw[`BPS_BIT_DATA_PAR]   = data_par;
		status_hw[`BPS_SEL_HI:`BPS_SEL_LO] = `BPS_SEL_SPEED_MEDIUM;
		status_hw[`BPS_BIT_SIG_TABORT] = sig_tabort;
		status_hw[`BPS_BIT_RCV_TABORT] = rcv_tabort;
		status_hw[`BPS_BIT_RCV_MABORT] = rcv_mabort;
		status_hw[`BPS_BIT_SIG_SERR]   = sig_serr;
		status_hw[`BPS_BIT_DET_PAR]    = det_par;
		case (cfg_addr)
			`BPS_ADDR_STATUS: next_rdata = {status_hw, 16'h0000};
			`BPS_ADDR_CLASS: next_rdata = {`BPS_BASE_CLASS, `BPS_SUBCLASS,
				`BPS_PROG_IF, `BPS_REV_CODE};
			`BPS_ADDR_CACHE: next_rdata = {24'h000000, cache_line_size};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_rdata <= 32'h00000000;
			cfg_ack   <= 1'b0;
		end else begin
			cfg_ack <= cfg_rd || cfg_wr;
			if (cfg_rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end
endmodule // bps_regs

// file: tb/bps_cfg_master.sv
// Purpose: configuration master on the primary bus
// Assumes: tasks called just after a rising edge
// Notes: idle clears cfg_rd and cfg_wr and inverts the last cfg_addr and cfg_wdata
`timescale 1ns/1ps
module bps_cfg_master (
	input  wire        clk,
	output reg         cfg_rd,
	output reg         cfg_wr,
	output reg  [7:0]  cfg_addr,
	output reg  [3:0]  be_n,
	output reg  [31:0] cfg_wdata
);
	initial {cfg_rd, cfg_wr, cfg_addr, be_n, cfg_wdata} = 0;
	task acc(input w, input [7:0] a, input [3:0] b, input [31:0] d);
		begin
			{cfg_wr, cfg_rd, cfg_addr, be_n, cfg_wdata} = {w, !w, a, b, d};
			@(posedge clk) #1;
		end
	endtask
	task idle;
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'h0, ~cfg_addr, ~cfg_wdata};
	endtask
endmodule // bps_cfg_master

// file: tb/bps_regs_checker.sv
// Purpose: port checks for bps_regs
// Assumes: one clock, async active-low reset
// Notes: bound below
`timescale 1ns/1ps
`include "bps_consts.vh"
module bps_regs_checker (
	input wire        clk,
	input wire        nrst,
	input wire        cfg_rd,
	input wire        cfg_wr,
	input wire [7:0]  cfg_addr,
	input wire [3:0]  primary_byte_enables_n,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire        cfg_ack,
	input wire [7:0]  cache_line_size,
	input wire [7:0]  line_dwords
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	function [7:0] eff(input [7:0] v);
		eff = (v != 0 && v <= 16 && (v & (v - 1)) == 0) ? v : 8'h10;
	endfunction
	wire rq = cfg_rd | cfg_wr;
	wire cw = cfg_wr && cfg_addr == 8'h0C;
	property p_ack; rq |=> cfg_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack");
	property p_nak; !rq |=> !cfg_ack; endproperty
	a_nak: assert property (p_nak) else $error("stray ack");
	property p_cls; cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata == {24'h060400, `BPS_REV_CODE}; endproperty
	a_cls: assert property (p_cls) else $error("class");
	property p_rsv; cfg_rd && cfg_addr == 8'h04 |=> !cfg_rdata[22] && cfg_rdata[19:16] == 0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_cap; cfg_rd && cfg_addr == 8'h04 |=> cfg_rdata[26:25] == 2'h1 && cfg_rdata[23] && cfg_rdata[20]; endproperty
	a_cap: assert property (p_cap) else $error("fixed bits");
	property p_clw; cw && !primary_byte_enables_n[0] |=> cache_line_size == $past(cfg_wdata[7:0]); endproperty
	a_clw: assert property (p_clw) else $error("line write");
	property p_clh; !(cw && !primary_byte_enables_n[0]) |=> $stable(cache_line_size); endproperty
	a_clh: assert property (p_clh) else $error("line hold");
	property p_eff; 1 |=> line_dwords == eff($past(cache_line_size)); endproperty
	a_eff: assert property (p_eff) else $error("line length");
endmodule // bps_regs_checker
bind bps_regs bps_regs_checker u_chk (.clk(clk), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
	.cfg_addr(cfg_addr), .primary_byte_enables_n(primary_byte_enables_n), .cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cache_line_size(cache_line_size),
	.line_dwords(line_dwords));

// file: tb/bridge_primary_status_id_regs_tb_top.sv
// Purpose: self-checking bench for bps_regs
// Assumes: 25 MHz clock, inputs 1 ns after the edge
// Notes: reads compared through an expectation queue
`timescale 1ns/1ps
`include "bps_consts.vh"
module bridge_primary_status_id_regs_tb_top;
	localparam [31:0] CLS = {24'h060400, `BPS_REV_CODE};
	reg         clk = 0, nrst = 0, strap = 0, mact = 0, pen = 0, rd_d = 0, perr_n = 1;
	reg  [5:0]  ev = 0;
	reg  [7:0]  v;
	reg  [31:0] st, r, q[$];
	integer     n_fail = 0, checks_done = 0, i, seed = 32'h99a4;
	wire        rd, wr, ack;
	wire [7:0]  a, cls, ld;
	wire [3:0]  be;
	wire [31:0] wd, rdt;
	initial forever #20 clk = ~clk;
	bps_cfg_master m (.clk(clk), .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(a), .be_n(be), .cfg_wdata(wd));
	bps_regs dut (.clk(clk), .nrst(nrst), .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(a),
		.primary_byte_enables_n(be), .cfg_wdata(wd), .cfg_rdata(rdt), .cfg_ack(ack),
		.parity_resp_en(pen), .speed_strap_pin(strap), .primary_parity_error_pin_n(perr_n),
		.master_active(mact), .parity_err_det(ev[5]), .addr_parity_err(ev[4]),
		.tgt_abort_signalled(ev[0]), .tgt_abort_received(ev[1]), .mst_abort_received(ev[2]),
		.system_error_driven(ev[3]), .cache_line_size(cls), .line_dwords(ld));
	function [7:0] eff(input [7:0] x);
		eff = (x != 0 && x <= 16 && (x & (x - 1)) == 0) ? x : 8'h10;
	endfunction
	task chk(input [8*5:1] nm, input [31:0] e, input [31:0] s);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_fail);
			if (n_fail == 0 && checks_done > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task rdq(input [7:0] ad, input [31:0] e);
		begin
			m.acc(0, ad, 4'h0, 0);
			q.push_back(e);
		end
	endtask
	task pulse(input [5:0] p);
		begin
			m.idle;
			ev = p;
			@(posedge clk) #1 ev = 0;
		end
	endtask
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk)
		if (ack === 1'b1 && rd_d) begin
			chk("rdata", q[0], rdt);
			q.pop_front();
		end
	initial begin
		repeat (3000) @(posedge clk);
		n_fail = n_fail + 1;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 nrst = 1;
		st = 32'h02900000;
		rdq(`BPS_ADDR_STATUS, st);
		rdq(`BPS_ADDR_CACHE, 0);
		rdq(`BPS_ADDR_CLASS, CLS);
		rdq(8'h10, 0);
		pulse(0);
		strap = 1;
		repeat (5) @(posedge clk) #1;
		st[21] = 1;
		rdq(`BPS_ADDR_STATUS, st);
		for (i = 0; i < 5; i = i + 1) begin
			pulse(6'h1 << i);
			rdq(`BPS_ADDR_STATUS, st | 32'h1 << (27 + i));
			m.acc(1, `BPS_ADDR_STATUS, 4'h0, ~(32'h1 << (27 + i)));
			rdq(`BPS_ADDR_STATUS, st | 32'h1 << (27 + i));
			m.acc(1, `BPS_ADDR_STATUS, 4'h0, 32'h1 << (27 + i));
			rdq(`BPS_ADDR_STATUS, st);
		end
		mact = 1;
		for (i = 0; i < 2; i = i + 1) begin
			pen = i[0];
			pulse(6'h20);
			rdq(`BPS_ADDR_STATUS, st | {7'h40, i[0], 24'h0});
			m.acc(1, `BPS_ADDR_STATUS, 4'h0, 32'h81000000);
			rdq(`BPS_ADDR_STATUS, st);
		end
		for (i = 0; i < 2; i = i + 1) begin
			mact = i[0];
			pen = 1;
			perr_n = 0;
			pulse(0);
			pulse(0);
			pulse(0);
			perr_n = 1;
			pulse(0);
			pulse(0);
			rdq(`BPS_ADDR_STATUS, st | {7'h00, i[0], 24'h0});
			m.acc(1, `BPS_ADDR_STATUS, 4'h0, 32'h81000000);
			rdq(`BPS_ADDR_STATUS, st);
		end
		for (i = 0; i < 12; i = i + 1) begin
			r = $random(seed);
			v = i < 6 ? 8'h01 << i : (i == 6 ? 8'h00 : r[7:0]);
			m.acc(1, `BPS_ADDR_CACHE, 4'hE, {r[31:8], v});
			m.acc(1, `BPS_ADDR_CACHE, 4'h1, ~r);
			m.acc(1, `BPS_ADDR_CLASS, 4'h0, r);
			rdq(`BPS_ADDR_CACHE, {24'h0, v});
			rdq(`BPS_ADDR_CLASS, CLS);
			pulse(0);
			chk("line", eff(v), ld);
		end
		repeat (3) @(posedge clk);
		give_verdict;
	end
endmodule // bridge_primary_status_id_regs_tb_top
